// ===== rtl/fsc_ctrl.v
// Frequency entry, limit checking and sweep sequencing for a synthesizer.
// Assumes one-cycle key and knob pulses synchronous to clock, and a
// synthesizer that takes freq_word whenever freq_load pulses.
`timescale 1ns/100ps
`default_nettype none
`include "fsc_defines.vh"
module fsc_ctrl #(
  parameter MS_CYC = `FSC_MS_CYC
) (
  // Clock, reset and clock enable.
  input  wire        clock,
  input  wire        rstn,
  input  wire        ce,
  // Keyboard, tuning knob and standby switch.
  input  wire        key_valid,
  input  wire [4:0]  key_code,
  input  wire        knob_step,
  input  wire        knob_ccw,
  input  wire        standby,
  // Register port.
  input  wire [2:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output wire [31:0] reg_rdata,
  // Synthesizer frequency word.
  output wire [31:0] freq_word,
  output wire        freq_load,
  // Readout and lamps.
  output wire [31:0] readout_hz,
  output wire [1:0]  readout_src,
  output wire [47:0] entry_bcd,
  output wire [3:0]  entry_nfrac,
  output wire [3:0]  unit_flash,
  output wire        range_lamp,
  output wire        sweep_lamp,
  output wire [2:0]  tune_sel
);
  localparam ST_IDLE = 1'b0;
  localparam ST_CONV = 1'b1;
  localparam SW_IDLE = 1'b0;
  localparam SW_RUN  = 1'b1;

  // Stored settings.
  reg [31:0] cf_r;
  reg [31:0] width_r;
  reg [31:0] step_r;
  reg [31:0] lim_lo_r;
  reg [31:0] lim_hi_r;
  reg [1:0]  mode_r;
  reg [1:0]  rate_r;
  reg [2:0]  tune_r;
  // Keyboard entry state.
  reg        st_r;
  reg        shift_r;
  reg        ent_r;
  reg        val_ok_r;
  reg        point_r;
  reg        conv_go_r;
  reg [47:0] bcd_r;
  reg [3:0]  ndig_r;
  reg [3:0]  nfrac_r;
  reg [1:0]  units_r;
  // Readout and lamp timers.
  reg [9:0]  show_r;
  reg        show_wid_r;
  reg [7:0]  flash_r;
  reg [31:0] readout_r;
  reg [1:0]  rsrc_r;
  // Sweep state.
  reg        sw_st_r;
  reg [9:0]  k_r;
  reg [31:0] off_r;
  reg [9:0]  rem_r;
  reg [31:0] pos_r;
  // Outputs from flip-flops.
  reg [31:0] freq_r;
  reg        load_r;
  reg [31:0] rdata_r;
  // Combinational center candidate.
  reg [32:0] cand;
  reg        cand_en;
  reg [31:0] knob_inc;
  reg [3:0]  expo;
  reg [31:0] freq_nxt;
  reg [31:0] rd_mux;

  wire        tick_ms;
  wire        tick_slow;
  wire        conv_busy;
  wire        conv_done;
  wire [39:0] conv_val;

  // Key decode.
  wire key_ok   = ce & key_valid & (st_r == ST_IDLE);
  wire plain    = key_ok & ~shift_r;
  wire shifted  = key_ok & shift_r;
  wire is_digit = key_code <= `FSC_KEY_9;
  wire is_unit  = (key_code >= `FSC_KEY_GHZ) && (key_code <= `FSC_KEY_HZ);
  wire [4:0] uoff = key_code - `FSC_KEY_GHZ;
  wire is_step  = (key_code == `FSC_KEY_UP) || (key_code == `FSC_KEY_DOWN);
  wire do_init  = ce & (standby | (plain & (key_code == `FSC_KEY_RESET)));
  wire [32:0] conv33 = (|conv_val[39:32]) ? {1'b1, 32'h0} : {1'b0, conv_val[31:0]};
  wire over = cand > {1'b0, lim_hi_r};
  // Centers at or above the high-resolution boundary keep even hertz only.
  wire [31:0] cand_res = (cand[31:0] >= `FSC_HIRES_HZ) ?
                         {cand[31:1], 1'b0} : cand[31:0];

  // Sweep step size and remainder for the selected number of steps.
  wire        fast   = rate_r == `FSC_RATE_FAST;
  wire [9:0]  nsteps = fast ? `FSC_FAST_N : `FSC_MED_N;
  wire [31:0] q_n    = fast ? width_r / 100 : width_r / 1000;
  wire [31:0] r_n    = fast ? width_r % 100 : width_r % 1000;
  wire [31:0] q_man  = width_r / 1000;
  // One bit wider than the remainder so two near-full remainders cannot wrap.
  wire [10:0] rem_sum  = {1'b0, rem_r} + {1'b0, r_n[9:0]};
  wire [10:0] rem_wrap = rem_sum - {1'b0, nsteps};
  wire        step_tick = (rate_r == `FSC_RATE_SLOW) ? tick_slow : tick_ms;
  // Lower sweep edge, clamped at zero hertz.
  wire [32:0] lo33 = {1'b0, cf_r} - {2'h0, width_r[31:1]};
  wire [31:0] lo   = lo33[32] ? 32'h0 : lo33[31:0];
  wire sweeping = sw_st_r == SW_RUN;

  fsc_tick #(
    .MS_CYC (MS_CYC)
  ) u_tick (
    .clock     (clock),
    .rstn      (rstn),
    .ce        (ce),
    .tick_ms   (tick_ms),
    .tick_slow (tick_slow)
  );

  fsc_conv u_conv (
    .clock  (clock),
    .rstn   (rstn),
    .ce     (ce),
    .start  (conv_go_r),
    .digits (bcd_r),
    .nfrac  (nfrac_r),
    .expo   (expo),
    .busy   (conv_busy),
    .done   (conv_done),
    .value  (conv_val)
  );

  // Exponent and knob increment from the latched unit and tuning setting.
  always @* begin
    case (units_r)
      2'h0:    expo = `FSC_EXP_GHZ;
      2'h1:    expo = `FSC_EXP_MHZ;
      2'h2:    expo = `FSC_EXP_KHZ;
      default: expo = `FSC_EXP_HZ;
    endcase
    case (tune_r)
      `FSC_TUNE_FINE:   knob_inc = `FSC_FINE_HZ;
      `FSC_TUNE_MEDIUM: knob_inc = `FSC_MEDIUM_HZ;
      `FSC_TUNE_COARSE: knob_inc = `FSC_COARSE_HZ;
      default:          knob_inc = step_r;
    endcase
  end

  // Picks the new center proposed by an entry, a step key or the knob.
  always @* begin
    cand    = {1'b0, cf_r};
    cand_en = 1'b0;
    if (plain && key_code == `FSC_KEY_CF && val_ok_r) begin
      cand    = conv33;
      cand_en = 1'b1;
    end else if (plain && is_step && !ent_r) begin
      cand_en = 1'b1;
      if (key_code == `FSC_KEY_UP)
        cand = {1'b0, cf_r} + {1'b0, step_r};
      else
        cand = {1'b0, cf_r} - {1'b0, step_r};
    end else if (ce && knob_step && !key_ok && mode_r != `FSC_MODE_MANUAL &&
                 tune_r != `FSC_TUNE_OFF) begin
      cand_en = 1'b1;
      if (knob_ccw)
        cand = {1'b0, cf_r} - {1'b0, knob_inc};
      else
        cand = {1'b0, cf_r} + {1'b0, knob_inc};
    end
  end

  // Keyboard entry, center, width and step registers, and lamp timers.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cf_r       <= `FSC_CF_RST;
      width_r    <= `FSC_WIDTH_RST;
      step_r     <= `FSC_STEP_RST;
      tune_r     <= `FSC_TUNE_OFF;
      st_r       <= ST_IDLE;
      shift_r    <= 1'b0;
      ent_r      <= 1'b0;
      val_ok_r   <= 1'b0;
      point_r    <= 1'b0;
      conv_go_r  <= 1'b0;
      bcd_r      <= 48'h0;
      ndig_r     <= 4'h0;
      nfrac_r    <= 4'h0;
      units_r    <= 2'h0;
      show_r     <= 10'h0;
      show_wid_r <= 1'b0;
      flash_r    <= 8'h0;
    end else if (ce) begin
      conv_go_r <= 1'b0;
      if (tick_ms && show_r != 10'h0)
        show_r <= show_r - 10'h1;
      if (tick_ms && flash_r != 8'h0)
        flash_r <= flash_r - 8'h1;
      // Over the upper limit the old center stays and the lamp flashes once.
      if (cand_en && over)
        flash_r <= `FSC_FLASH_MS;
      else if (cand_en)
        cf_r <= cand_res;
      case (st_r)
        ST_IDLE: begin
          if (shifted) begin
            shift_r <= 1'b0;
            if (is_step || key_code == `FSC_KEY_WIDTH) begin
              show_r     <= `FSC_SHOW_MS;
              show_wid_r <= key_code == `FSC_KEY_WIDTH;
            end else if (key_code == `FSC_KEY_CLEAR) begin
              ent_r    <= 1'b0;
              val_ok_r <= 1'b0;
            end
          end else if (plain && is_digit) begin
            show_r <= 10'h0;
            ent_r  <= 1'b1;
            if (val_ok_r || !ent_r) begin
              bcd_r    <= {44'h0, key_code[3:0]};
              ndig_r   <= 4'h1;
              nfrac_r  <= 4'h0;
              point_r  <= 1'b0;
              val_ok_r <= 1'b0;
            end else if (ndig_r < `FSC_MAX_DIG) begin
              bcd_r   <= {bcd_r[43:0], key_code[3:0]};
              ndig_r  <= ndig_r + 4'h1;
              nfrac_r <= nfrac_r + {3'h0, point_r};
            end
          end else if (plain && key_code == `FSC_KEY_POINT) begin
            ent_r   <= 1'b1;
            point_r <= 1'b1;
            if (val_ok_r || !ent_r) begin
              bcd_r    <= 48'h0;
              ndig_r   <= 4'h0;
              nfrac_r  <= 4'h0;
              val_ok_r <= 1'b0;
            end
          end else if (plain && is_unit && ent_r) begin
            units_r   <= uoff[1:0];
            val_ok_r  <= 1'b0;
            conv_go_r <= 1'b1;
            st_r      <= ST_CONV;
          end else if (plain && key_code == `FSC_KEY_SHIFT) begin
            shift_r <= 1'b1;
          end else if (plain && key_code == `FSC_KEY_TUNE) begin
            if (tune_r == `FSC_TUNE_STEP)
              tune_r <= `FSC_TUNE_OFF;
            else
              tune_r <= tune_r + 3'h1;
          end else if (plain && key_code == `FSC_KEY_CLEAR) begin
            ent_r    <= 1'b0;
            val_ok_r <= 1'b0;
            show_r   <= 10'h0;
          end else if (plain && (key_code == `FSC_KEY_CF || is_step ||
                                 key_code == `FSC_KEY_WIDTH)) begin
            if (val_ok_r && is_step)
              step_r <= conv_val[31:0];
            if (val_ok_r && key_code == `FSC_KEY_WIDTH)
              width_r <= conv_val[31:0];
            ent_r    <= 1'b0;
            val_ok_r <= 1'b0;
          end
        end
        ST_CONV: begin
          if (conv_done && !conv_busy) begin
            val_ok_r <= 1'b1;
            st_r     <= ST_IDLE;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
      // Reset key and standby restore the power-up center, width, step and tuning; the sweep rate and the limits keep their values.
      if (do_init) begin
        cf_r     <= `FSC_CF_RST;
        width_r  <= `FSC_WIDTH_RST;
        step_r   <= `FSC_STEP_RST;
        tune_r   <= `FSC_TUNE_OFF;
        ent_r    <= 1'b0;
        val_ok_r <= 1'b0;
        shift_r  <= 1'b0;
        show_r   <= 10'h0;
        st_r     <= ST_IDLE;
      end
    end
  end

  // Register writes: sweep mode, rate and the plug-in limits.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      mode_r   <= `FSC_MODE_OFF;
      rate_r   <= `FSC_RATE_FAST;
      lim_lo_r <= `FSC_LIMLO_RST;
      lim_hi_r <= `FSC_LIMHI_RST;
    end else if (ce) begin
      if (reg_wr && reg_addr == `FSC_A_CTRL) begin
        mode_r <= reg_wdata[`FSC_CTRL_MODE_LSB+1:`FSC_CTRL_MODE_LSB];
        rate_r <= reg_wdata[`FSC_CTRL_RATE_LSB+1:`FSC_CTRL_RATE_LSB];
      end
      if (reg_wr && reg_addr == `FSC_A_LIMLO)
        lim_lo_r <= reg_wdata;
      if (reg_wr && reg_addr == `FSC_A_LIMHI)
        lim_hi_r <= reg_wdata;
      if (do_init)
        mode_r <= `FSC_MODE_OFF;
    end
  end

  // Sweep sequencer and manual sweep position.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sw_st_r <= SW_IDLE;
      k_r     <= 10'h0;
      off_r   <= 32'h0;
      rem_r   <= 10'h0;
      pos_r   <= 32'h0;
    end else if (ce) begin
      case (sw_st_r)
        SW_IDLE: begin
          k_r   <= 10'h0;
          off_r <= 32'h0;
          rem_r <= 10'h0;
          if (mode_r == `FSC_MODE_AUTO)
            sw_st_r <= SW_RUN;
          else if (mode_r == `FSC_MODE_SINGLE && plain &&
                   key_code == `FSC_KEY_SINGLE)
            sw_st_r <= SW_RUN;
        end
        SW_RUN: begin
          if (mode_r != `FSC_MODE_AUTO && mode_r != `FSC_MODE_SINGLE) begin
            sw_st_r <= SW_IDLE;
          end else if (step_tick && k_r == nsteps - 10'h1) begin
            k_r   <= 10'h0;
            off_r <= 32'h0;
            rem_r <= 10'h0;
            if (mode_r == `FSC_MODE_SINGLE)
              sw_st_r <= SW_IDLE;
          end else if (step_tick) begin
            // Carries the remainder so step k lands on k times the width over the step count, without drift.
            k_r <= k_r + 10'h1;
            if (rem_sum >= {1'b0, nsteps}) begin
              off_r <= off_r + q_n + 32'h1;
              rem_r <= rem_wrap[9:0];
            end else begin
              off_r <= off_r + q_n;
              rem_r <= rem_sum[9:0];
            end
          end
        end
        default: sw_st_r <= SW_IDLE;
      endcase
      // Outside manual mode the knob position rests at the center.
      if (mode_r != `FSC_MODE_MANUAL || do_init)
        pos_r <= {1'b0, width_r[31:1]};
      else if (knob_step && !knob_ccw)
        pos_r <= (pos_r + q_man > width_r) ? width_r : pos_r + q_man;
      else if (knob_step)
        pos_r <= (pos_r < q_man) ? 32'h0 : pos_r - q_man;
    end
  end

  // Instantaneous output frequency for the synthesizer.
  always @* begin
    if (sweeping)
      freq_nxt = lo + off_r;
    else if (mode_r == `FSC_MODE_MANUAL)
      freq_nxt = lo + pos_r;
    else
      freq_nxt = cf_r;
  end

  // Register read multiplexer.
  always @* begin
    case (reg_addr)
      `FSC_A_CTRL:  rd_mux = {28'h0, rate_r, mode_r};
      `FSC_A_LIMLO: rd_mux = lim_lo_r;
      `FSC_A_LIMHI: rd_mux = lim_hi_r;
      `FSC_A_CF:    rd_mux = cf_r;
      `FSC_A_FREQ:  rd_mux = freq_r;
      `FSC_A_STAT:  rd_mux = {25'h0, tune_r, val_ok_r, ent_r, range_lamp, sweeping};
      `FSC_A_WIDTH: rd_mux = width_r;
      default:      rd_mux = step_r;
    endcase
  end

  // Frequency word, readout and read data registers.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      freq_r    <= `FSC_CF_RST;
      load_r    <= 1'b0;
      readout_r <= `FSC_CF_RST;
      rsrc_r    <= `FSC_SRC_CF;
      rdata_r   <= 32'h0;
    end else if (ce) begin
      freq_r  <= freq_nxt;
      load_r  <= freq_nxt != freq_r;
      rdata_r <= reg_rd ? rd_mux : 32'h0;
      if (show_r != 10'h0) begin
        readout_r <= show_wid_r ? width_r : step_r;
        rsrc_r    <= `FSC_SRC_SHOW;
      end else if (ent_r) begin
        readout_r <= val_ok_r ? conv_val[31:0] : 32'h0;
        rsrc_r    <= `FSC_SRC_ENTRY;
      end else begin
        readout_r <= cf_r;
        rsrc_r    <= `FSC_SRC_CF;
      end
    end
  end

  // Units lamp flashes only once a units key has scaled the entry.
  assign unit_flash  = (ent_r && val_ok_r) ? (4'h1 << units_r) : 4'h0;
  // Range lamp: steady below the lower limit, a single flash on refusal.
  assign range_lamp  = (freq_r < lim_lo_r) || (flash_r != 8'h0);
  assign sweep_lamp  = mode_r != `FSC_MODE_OFF;
  assign tune_sel    = tune_r;
  assign freq_word   = freq_r;
  assign freq_load   = load_r;
  assign readout_hz  = readout_r;
  assign readout_src = rsrc_r;
  assign entry_bcd   = bcd_r;
  assign entry_nfrac = nfrac_r;
  assign reg_rdata   = rdata_r;
endmodule // fsc_ctrl
`default_nettype wire

// ===== rtl/fsc_defines.vh
// Shared constants for the frequency entry and sweep controller.
// Assumes a 125 MHz system clock; included by bare name from each design file.
`ifndef FSC_DEFINES_VH
`define FSC_DEFINES_VH
// Timing.
`define FSC_CLK_NS 8
`define FSC_STEP_MS 1
`define FSC_MS_CYC (`FSC_STEP_MS * 1000000 / `FSC_CLK_NS)
`define FSC_SLOW_MS 6'h32
`define FSC_FLASH_MS 8'hc8
`define FSC_SHOW_MS 10'h3e8
`define FSC_FAST_N 10'h064
`define FSC_MED_N 10'h3e8
// Register offsets and control fields.
`define FSC_A_CTRL 3'h0
`define FSC_A_LIMLO 3'h1
`define FSC_A_LIMHI 3'h2
`define FSC_A_CF 3'h3
`define FSC_A_FREQ 3'h4
`define FSC_A_STAT 3'h5
`define FSC_A_WIDTH 3'h6
`define FSC_A_STEP 3'h7
`define FSC_CTRL_MODE_LSB 0
`define FSC_CTRL_RATE_LSB 2
// Reset values and frequency figures in hertz.
`define FSC_CF_RST 32'h000f4240
`define FSC_WIDTH_RST 32'h001e8480
`define FSC_STEP_RST 32'h004c4b40
`define FSC_LIMLO_RST 32'h00002710
`define FSC_LIMHI_RST 32'h068e777f
`define FSC_HIRES_HZ 32'h4d7c6d00
`define FSC_FINE_HZ 32'h00000001
`define FSC_MEDIUM_HZ 32'h000003e8
`define FSC_COARSE_HZ 32'h000f4240
// Sweep modes, rates and tuning settings.
`define FSC_MODE_OFF 2'h0
`define FSC_MODE_AUTO 2'h1
`define FSC_MODE_SINGLE 2'h2
`define FSC_MODE_MANUAL 2'h3
`define FSC_RATE_FAST 2'h0
`define FSC_RATE_SLOW 2'h2
`define FSC_TUNE_OFF 3'h0
`define FSC_TUNE_FINE 3'h1
`define FSC_TUNE_MEDIUM 3'h2
`define FSC_TUNE_COARSE 3'h3
`define FSC_TUNE_STEP 3'h4
// Key codes; digits are codes 0 to 9.
`define FSC_KEY_9 5'h09
`define FSC_KEY_POINT 5'h0a
`define FSC_KEY_GHZ 5'h0b
`define FSC_KEY_HZ 5'h0e
`define FSC_KEY_CF 5'h0f
`define FSC_KEY_UP 5'h10
`define FSC_KEY_DOWN 5'h11
`define FSC_KEY_WIDTH 5'h12
`define FSC_KEY_SHIFT 5'h13
`define FSC_KEY_CLEAR 5'h14
`define FSC_KEY_SINGLE 5'h15
`define FSC_KEY_TUNE 5'h16
`define FSC_KEY_RESET 5'h17
// Units exponents and readout sources.
`define FSC_EXP_GHZ 4'h9
`define FSC_EXP_MHZ 4'h6
`define FSC_EXP_KHZ 4'h3
`define FSC_EXP_HZ 4'h0
`define FSC_MAX_DIG 4'hc
`define FSC_SRC_CF 2'h0
`define FSC_SRC_ENTRY 2'h1
`define FSC_SRC_SHOW 2'h2
`endif

// ===== rtl/fsc_conv.v
// Decimal entry converter: twelve BCD digits to a binary hertz value.
// Assumes the caller holds digits, fraction count and exponent while busy.
`timescale 1ns/100ps
`default_nettype none
`include "fsc_defines.vh"
module fsc_conv (
  // Clock, reset and enable.
  input  wire        clock,
  input  wire        rstn,
  input  wire        ce,
  // Request.
  input  wire        start,
  input  wire [47:0] digits,
  input  wire [3:0]  nfrac,
  input  wire [3:0]  expo,
  // Result.
  output wire        busy,
  output wire        done,
  output wire [39:0] value
);
  reg        busy_r;
  reg        done_r;
  reg        pad_ph_r;
  reg [3:0]  idx_r;
  reg [3:0]  pad_r;
  reg [39:0] acc_r;
  wire [3:0]  digit = digits[idx_r*4 +: 4];
  wire [39:0] acc10 = {acc_r[36:0], 3'h0} + {acc_r[38:0], 1'h0};
  // A digit is kept unless it lies deeper in the fraction than the unit shows.
  wire        keep  = ({1'b0, idx_r} + {1'b0, expo}) >= {1'b0, nfrac};

  // Walks the digits from the left, then pads with zeros up to the unit.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      busy_r   <= 1'b0;
      done_r   <= 1'b0;
      pad_ph_r <= 1'b0;
      idx_r    <= 4'h0;
      pad_r    <= 4'h0;
      acc_r    <= 40'h0;
    end else if (ce) begin
      done_r <= 1'b0;
      if (start) begin
        busy_r   <= 1'b1;
        pad_ph_r <= 1'b0;
        idx_r    <= `FSC_MAX_DIG - 4'h1;
        acc_r    <= 40'h0;
        pad_r    <= (expo > nfrac) ? (expo - nfrac) : 4'h0;
      end else if (busy_r && !pad_ph_r) begin
        if (keep)
          acc_r <= acc10 + {36'h0, digit};
        if (idx_r == 4'h0)
          pad_ph_r <= 1'b1;
        else
          idx_r <= idx_r - 4'h1;
      end else if (busy_r && pad_r != 4'h0) begin
        acc_r <= acc10;
        pad_r <= pad_r - 4'h1;
      end else if (busy_r) begin
        busy_r <= 1'b0;
        done_r <= 1'b1;
      end
    end
  end

  assign busy  = busy_r;
  assign done  = done_r;
  assign value = acc_r;
endmodule // fsc_conv
`default_nettype wire

// ===== rtl/fsc_tick.v
// Millisecond and slow-rate tick generator for sweep and lamp timing.
// Assumes the clock runs at the rate that MS_CYC was derived for.
`timescale 1ns/100ps
`default_nettype none
`include "fsc_defines.vh"
module fsc_tick #(
  parameter MS_CYC = `FSC_MS_CYC
) (
  // Clock, reset and enable.
  input  wire clock,
  input  wire rstn,
  input  wire ce,
  // Ticks, one cycle each.
  output wire tick_ms,
  output wire tick_slow
);
  reg [31:0] cnt_r;
  reg [5:0]  slow_cnt_r;
  reg        ms_r;
  reg        slow_r;

  // Counts clocks to one millisecond, then milliseconds to a slow step.
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_r      <= 32'h0;
      slow_cnt_r <= 6'h0;
      ms_r       <= 1'b0;
      slow_r     <= 1'b0;
    end else if (ce) begin
      ms_r   <= 1'b0;
      slow_r <= 1'b0;
      if (cnt_r == MS_CYC - 1) begin
        cnt_r <= 32'h0;
        ms_r  <= 1'b1;
        if (slow_cnt_r == `FSC_SLOW_MS - 6'h1) begin
          slow_cnt_r <= 6'h0;
          slow_r     <= 1'b1;
        end else begin
          slow_cnt_r <= slow_cnt_r + 6'h1;
        end
      end else begin
        cnt_r <= cnt_r + 32'h1;
      end
    end
  end

  assign tick_ms   = ms_r & ce;
  assign tick_slow = slow_r & ce;
endmodule // fsc_tick
`default_nettype wire

// ===== bench/fsc_ctrl_chk.sv
// Port checker for the frequency entry and sweep controller.
// Assumes a bind to fsc_ctrl with the lower limit left at its reset value.
`timescale 1ns/100ps
`default_nettype none
`include "fsc_defines.vh"
module fsc_ctrl_chk #(
  parameter MS_CYC = 10
) (
  // Clock and reset.
  input wire logic        clock,
  input wire logic        rstn,
  // Watched ports.
  input wire logic        key_valid,
  input wire logic [4:0]  key_code,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [31:0] freq_word,
  input wire logic        freq_load,
  input wire logic [3:0]  unit_flash,
  input wire logic        range_lamp,
  input wire logic        sweep_lamp,
  input wire logic [2:0]  tune_sel
);
  // All checks run on the one clock and pause in reset.
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  load_pulse_a: assert property ($changed(freq_word) |-> ##[0:1] freq_load)
    else $error("word changed without load");
  tune_range_a: assert property (tune_sel <= `FSC_TUNE_STEP)
    else $error("bad tuning setting");
  lamp_onehot_a: assert property ($onehot0(unit_flash))
    else $error("two units lamps");
  range_low_a: assert property (freq_word < `FSC_LIMLO_RST |-> range_lamp)
    else $error("range lamp dark below limit");
  digit_dark_a: assert property (key_valid && key_code <= `FSC_KEY_9 |=> unit_flash == 4'h0)
    else $error("units lamp during digits");
  reset_key_a: assert property (key_valid && key_code == `FSC_KEY_RESET
    |-> ##[1:3] (tune_sel == `FSC_TUNE_OFF && !sweep_lamp))
    else $error("reset key left modes on");
  tune_step_a: assert property (key_valid && key_code == `FSC_KEY_TUNE
    && tune_sel == `FSC_TUNE_COARSE |-> ##[1:2] tune_sel == `FSC_TUNE_STEP)
    else $error("tuning did not reach step");
endmodule // fsc_ctrl_chk
`default_nettype wire

// ===== bench/fsc_synth_model.sv
// Synthesizer stand-in: latches the frequency word on each load pulse.
// Assumes freq_load is a one-cycle pulse beside a settled word.
`timescale 1ns/100ps
`default_nettype none
`include "fsc_defines.vh"
module fsc_synth_model (
  // Clock and reset.
  input wire logic        clock,
  input wire logic        rstn,
  // Word from the controller.
  input wire logic [31:0] freq_word,
  input wire logic        freq_load,
  // Frequency now tuned.
  output logic [31:0]     tuned_hz
);
  // Take the word only on a load pulse.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) tuned_hz <= `FSC_CF_RST;
    else if (freq_load) tuned_hz <= freq_word;
  end
endmodule // fsc_synth_model
`default_nettype wire

// ===== bench/fsc_ctrl_tb.sv
// Testbench for the frequency controller with a synthesizer stand-in.
// Assumes a 125 MHz clock and keys spaced beyond the conversion time.
`timescale 1ns/100ps
`default_nettype none
`include "fsc_defines.vh"
module fsc_ctrl_tb;
  localparam MS_CYC = 10;
  logic        clock, rstn, key_valid, knob_step, knob_ccw, reg_wr, reg_rd;
  logic        freq_load, range_lamp, sweep_lamp, ce, standby;
  logic [4:0]  key_code;
  logic [2:0]  reg_addr, tune_sel;
  logic [1:0]  readout_src;
  logic [3:0]  unit_flash, entry_nfrac;
  logic [47:0] entry_bcd;
  logic [31:0] reg_wdata, reg_rdata, freq_word, readout_hz, tuned_hz;
  int          err_count, checks;
  fsc_ctrl #(.MS_CYC(MS_CYC)) dut (.clock(clock), .rstn(rstn), .ce(ce),
    .key_valid(key_valid), .key_code(key_code), .knob_step(knob_step), .knob_ccw(knob_ccw),
    .standby(standby), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .freq_word(freq_word), .freq_load(freq_load),
    .readout_hz(readout_hz), .readout_src(readout_src), .entry_bcd(entry_bcd),
    .entry_nfrac(entry_nfrac),
    .unit_flash(unit_flash), .range_lamp(range_lamp), .sweep_lamp(sweep_lamp),
    .tune_sel(tune_sel));
  fsc_synth_model synth (.clock(clock), .rstn(rstn), .freq_word(freq_word),
    .freq_load(freq_load), .tuned_hz(tuned_hz));
  // Compares one value and counts it.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Presses keys one by one, leaving room for unit conversion.
  task automatic keys(input logic [4:0] k[$]);
    foreach (k[i]) begin
      key_code <= k[i];
      key_valid <= 1'b1;
      @(posedge clock) key_valid <= 1'b0;
      repeat (40) @(posedge clock);
    end
  endtask
  // Register read with data taken in the cycle after the strobe.
  task automatic rd(input logic [2:0] a, input logic [31:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock) reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
    @(posedge clock);
  endtask
  // Single-cycle register write.
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock) reg_wr <= 1'b0;
  endtask
  // One knob detent.
  task automatic knob(input logic ccw);
    knob_ccw <= ccw;
    knob_step <= 1'b1;
    @(posedge clock) knob_step <= 1'b0;
    repeat (10) @(posedge clock);
  endtask
  // Power-up values, 109 MHz entry, refused and applied steps.
  task automatic t_entry;
    chk(freq_word, `FSC_CF_RST);
    rd(`FSC_A_WIDTH, `FSC_WIDTH_RST);
    rd(`FSC_A_STEP, `FSC_STEP_RST);
    keys('{5'h01, 5'h00, 5'h09});
    chk(entry_bcd[31:0], 32'h00000109);
    chk({28'h0, unit_flash}, 32'h0);
    keys('{5'h0c});
    chk({28'h0, unit_flash}, 32'h2);
    keys('{`FSC_KEY_CF});
    chk(freq_word, 32'h067f3540);
    chk(tuned_hz, 32'h067f3540);
    keys('{`FSC_KEY_UP});
    chk({31'h0, range_lamp}, 32'h1);
    rd(`FSC_A_CF, 32'h067f3540);
    keys('{`FSC_KEY_DOWN});
    rd(`FSC_A_CF, 32'h0632ea00);
    keys('{5'h02, 5'h00, 5'h00, 5'h0c, `FSC_KEY_CF});
    rd(`FSC_A_CF, 32'h0632ea00);
  endtask
  // Knob, fractional low entry, sweep, freeze, reset, step show and standby.
  task automatic t_knob;
    logic [31:0] held;
    keys('{`FSC_KEY_TUNE, `FSC_KEY_TUNE, `FSC_KEY_TUNE, `FSC_KEY_TUNE});
    chk({29'h0, tune_sel}, {29'h0, `FSC_TUNE_STEP});
    knob(1'b1);
    rd(`FSC_A_CF, 32'h05e69ec0);
    knob(1'b0);
    rd(`FSC_A_CF, 32'h0632ea00);
    keys('{5'h05, `FSC_KEY_POINT, 5'h05, 5'h0d, `FSC_KEY_CF});
    chk({28'h0, entry_nfrac}, 32'h1);
    chk(freq_word, 32'h0000157c);
    chk({31'h0, range_lamp}, 32'h1);
    wr(`FSC_A_CF, 32'h0);
    rd(`FSC_A_CF, 32'h0000157c);
    wr(`FSC_A_CTRL, {30'h0, `FSC_MODE_AUTO});
    repeat (200) @(posedge clock);
    chk({31'h0, sweep_lamp}, 32'h1);
    // With the clock enable low the sweep must not move the word.
    ce <= 1'b0;
    @(posedge clock) held = freq_word;
    repeat (30) @(posedge clock);
    chk(freq_word, held);
    ce <= 1'b1;
    keys('{5'h01, `FSC_KEY_HZ, `FSC_KEY_UP});
    rd(`FSC_A_STEP, 32'h1);
    keys('{`FSC_KEY_RESET});
    rd(`FSC_A_CF, `FSC_CF_RST);
    rd(`FSC_A_STEP, `FSC_STEP_RST);
    chk({28'h0, tune_sel, sweep_lamp}, 32'h0);
    keys('{5'h01, `FSC_KEY_HZ, `FSC_KEY_UP, `FSC_KEY_SHIFT, `FSC_KEY_UP});
    chk(readout_hz, 32'h1);
    chk({30'h0, readout_src}, {30'h0, `FSC_SRC_SHOW});
    standby <= 1'b1;
    @(posedge clock) standby <= 1'b0;
    rd(`FSC_A_STEP, `FSC_STEP_RST);
  endtask
  // Free-running clock.
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Reset, scenarios, verdict.
  initial begin
    {rstn, key_valid, key_code, knob_step, knob_ccw, reg_wr, reg_rd, reg_addr} = '0;
    standby = 1'b0;
    ce = 1'b1;
    reg_wdata = 32'h0;
    err_count = 0;
    checks = 0;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    @(posedge clock);
    t_entry();
    t_knob();
    summarize();
  end
endmodule // fsc_ctrl_tb
bind fsc_ctrl fsc_ctrl_chk #(.MS_CYC(MS_CYC)) u_chk (.clock(clock), .rstn(rstn),
  .key_valid(key_valid), .key_code(key_code), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .freq_word(freq_word), .freq_load(freq_load), .unit_flash(unit_flash),
  .range_lamp(range_lamp), .sweep_lamp(sweep_lamp), .tune_sel(tune_sel));
`default_nettype wire
